// ---- src/charger_phase_config_regs.sv ----
`timescale 1ns/10ps
module charger_phase_config_regs import charger_cfg_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire reg_req_t req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// Charger input presence
	input wire logic charger_input_presence,
	input wire logic [1:0] input_detect_option,
	// Configuration to the charger
	output cfg_fields_t cfg,
	output cfg_decoded_t dec
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] prechg_reg, prechg_next;
	logic [7:0] timer_reg, timer_next;
	logic [7:0] step_reg, step_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic presence_reg;
	logic presence_seen_reg, presence_seen_next;
	logic edge_hit;
	cfg_fields_t cfg_reg, cfg_next;
	cfg_decoded_t dec_reg, dec_next;

	// Presence edge is qualified only after one sampled value exists,
	// so the first cycle out of reset cannot fake an edge.
	always_comb begin
		logic rise;
		logic fall;
		rise = charger_input_presence & ~presence_reg;
		fall = ~charger_input_presence & presence_reg;
		presence_seen_next = 1'b1;
		unique case (detect_opt_t'(input_detect_option))
			DET_NONE: edge_hit = 1'b0;
			DET_RISE: edge_hit = presence_seen_reg & rise;
			DET_FALL: edge_hit = presence_seen_reg & fall;
			DET_BOTH: edge_hit = presence_seen_reg & (rise | fall);
		endcase
	end

	// Edge beats a write in the same cycle: defaults win.
	always_comb begin
		prechg_next = prechg_reg;
		timer_next = timer_reg;
		step_next = step_reg;
		// Reset feeds the decode too, so dec is valid on the first
		// active cycle instead of showing all zeros
		if (!nrst) begin
			prechg_next = PRECHG_RST;
			timer_next = TIMER_RST;
			step_next = STEP_RST;
		end else if (edge_hit) begin
			prechg_next = PRECHG_RST;
			timer_next = TIMER_RST;
			step_next = STEP_RST;
		end else if (req.wr) begin
			unique case (req.addr)
				PRECHG_OFS: prechg_next = req.wdata;
				TIMER_OFS: timer_next = req.wdata;
				STEP_OFS: step_next = req.wdata & STEP_MASK;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rd_valid_next = req.rd;
		rd_data_next = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				PRECHG_OFS: rd_data_next = prechg_reg;
				TIMER_OFS: rd_data_next = timer_reg;
				STEP_OFS: rd_data_next = step_reg & STEP_MASK;
				default: rd_data_next = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Field and decode outputs
	// ----------------------------------------
	always_comb begin
		cfg_next.battery_pulldown_enable = prechg_next[PULLDOWN_BIT];
		cfg_next.precharge_voltage_threshold = prechg_next[PRE_V_LSB +: 3];
		cfg_next.precharge_current_select = prechg_next[PRE_I_LSB +: 2];
		cfg_next.done_current_threshold = prechg_next[DONE_I_LSB +: 2];
		cfg_next.maintain_auto_finish = timer_next[AUTO_FINISH_BIT];
		cfg_next.auto_recharge_enable = timer_next[AUTO_RECHG_BIT];
		cfg_next.maintain_timer_select = timer_next[MAINT_TMR_LSB +: 2];
		cfg_next.fast_timer_select = timer_next[FAST_TMR_LSB +: 2];
		cfg_next.pre_timer_select = timer_next[PRE_TMR_LSB +: 2];
		cfg_next.step_hysteresis_select = step_next[HYS_LSB +: 3];
		cfg_next.step_rise_threshold = step_next[RISE_LSB +: 4];
		dec_next.precharge_mv = PRE_V_BASE_MV + 12'(PRE_V_STEP_MV *
			cfg_next.precharge_voltage_threshold);
		dec_next.precharge_centi =
			CUR_CENTI[cfg_next.precharge_current_select];
		dec_next.done_centi = CUR_CENTI[cfg_next.done_current_threshold];
		dec_next.maintain_min = MAINT_MIN[cfg_next.maintain_timer_select];
		dec_next.fast_min = FAST_MIN[cfg_next.fast_timer_select];
		dec_next.pre_min = PRE_MIN[cfg_next.pre_timer_select];
		// Reserved codes decode linearly; software must avoid them
		dec_next.step_hys_mv = 12'(HYS_STEP_MV *
			({1'b0, cfg_next.step_hysteresis_select} + 4'h1));
		dec_next.step_rise_mv = RISE_BASE_MV + 13'(RISE_STEP_MV *
			cfg_next.step_rise_threshold);
	end

	// ----------------------------------------
	// Flip-flops
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			prechg_reg <= PRECHG_RST;
			timer_reg <= TIMER_RST;
			step_reg <= STEP_RST;
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			presence_reg <= 1'b0;
			presence_seen_reg <= 1'b0;
			cfg_reg <= cfg_next;
			dec_reg <= dec_next;
		end else begin
			prechg_reg <= prechg_next;
			timer_reg <= timer_next;
			step_reg <= step_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			presence_reg <= charger_input_presence;
			presence_seen_reg <= presence_seen_next;
			cfg_reg <= cfg_next;
			dec_reg <= dec_next;
		end
	end

	// Decoded outputs must agree with register defaults after reset
	always_comb begin
		rd_data = rd_data_reg;
		rd_valid = rd_valid_reg;
		cfg = cfg_reg;
		dec = dec_reg;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_edge_default;
		edge_hit |=> prechg_reg == PRECHG_RST && timer_reg == TIMER_RST &&
			step_reg == STEP_RST;
	endproperty
	a_edge_default: assert property (p_edge_default)
		else $error("fields not restored on presence edge");

	property p_pulldown;
		req.wr && req.addr == PRECHG_OFS && !edge_hit |=>
			cfg.battery_pulldown_enable == $past(req.wdata[7]);
	endproperty
	a_pulldown: assert property (p_pulldown)
		else $error("pulldown enable does not follow write");

	property p_pre_volt;
		dec.precharge_mv == 12'd2100 +
			12'd150 * 12'(cfg.precharge_voltage_threshold);
	endproperty
	a_pre_volt: assert property (p_pre_volt)
		else $error("precharge threshold decode wrong");

	property p_cur;
		cfg.precharge_current_select == 2'h3 |-> dec.precharge_centi == 6'd30;
	endproperty
	a_cur: assert property (p_cur)
		else $error("precharge current decode wrong");

	property p_auto;
		req.wr && req.addr == TIMER_OFS && !edge_hit |=>
			cfg.maintain_auto_finish == $past(req.wdata[7]) &&
			cfg.auto_recharge_enable == $past(req.wdata[6]);
	endproperty
	a_auto: assert property (p_auto)
		else $error("auto finish or recharge bit wrong");

	property p_timers;
		(cfg.maintain_timer_select != 2'h3 || dec.maintain_min == 10'd60) &&
		(cfg.fast_timer_select != 2'h0 || dec.fast_min == 10'd75) &&
		(cfg.pre_timer_select != 2'h3 || dec.pre_min == 10'd240);
	endproperty
	a_timers: assert property (p_timers)
		else $error("timer decode wrong");

	property p_step;
		dec.step_rise_mv == 13'd3800 + 13'd50 * 13'(cfg.step_rise_threshold) &&
		(cfg.step_hysteresis_select != 3'h5 || dec.step_hys_mv == 12'd600);
	endproperty
	a_step: assert property (p_step)
		else $error("step charge decode wrong");

	property p_step_bit7;
		req.rd && req.addr == STEP_OFS |=> rd_valid && rd_data[7] == 1'b0;
	endproperty
	a_step_bit7: assert property (p_step_bit7)
		else $error("step register bit 7 not zero");

	property p_readback;
		req.wr && req.addr == TIMER_OFS && !edge_hit ##1
			req.rd && req.addr == TIMER_OFS |=> rd_data == $past(req.wdata, 2);
	endproperty
	a_readback: assert property (p_readback)
		else $error("timer register readback mismatch");

	c_edge: cover property (edge_hit);
	c_write_step: cover property (req.wr && req.addr == STEP_OFS);
	c_read_pre: cover property (req.rd && req.addr == PRECHG_OFS);
	c_wr_edge: cover property (req.wr && edge_hit);
endmodule

// ---- src/charger_cfg_pkg.sv ----
package charger_cfg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] PRECHG_OFS = 8'h11;
	localparam logic [7:0] TIMER_OFS = 8'h12;
	localparam logic [7:0] STEP_OFS = 8'h13;
	// Values after reset or after an input-presence edge
	localparam logic [7:0] PRECHG_RST = 8'h00;
	localparam logic [7:0] TIMER_RST = 8'h00;
	localparam logic [7:0] STEP_RST = 8'h00;
	localparam logic [7:0] STEP_MASK = 8'h7f;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PULLDOWN_BIT = 7;
	localparam int PRE_V_LSB = 4;
	localparam int PRE_I_LSB = 2;
	localparam int DONE_I_LSB = 0;
	localparam int AUTO_FINISH_BIT = 7;
	localparam int AUTO_RECHG_BIT = 6;
	localparam int MAINT_TMR_LSB = 4;
	localparam int FAST_TMR_LSB = 2;
	localparam int PRE_TMR_LSB = 0;
	localparam int HYS_LSB = 4;
	localparam int RISE_LSB = 0;
	// ----------------------------------------
	// Decode tables
	// ----------------------------------------
	localparam logic [11:0] PRE_V_BASE_MV = 12'h834;
	localparam logic [11:0] PRE_V_STEP_MV = 12'h096;
	// Rise threshold tops out above 4095 mV, so it needs 13 bits
	localparam logic [12:0] RISE_BASE_MV = 13'h0ed8;
	localparam logic [12:0] RISE_STEP_MV = 13'h0032;
	localparam logic [11:0] HYS_STEP_MV = 12'h064;
	localparam logic [5:0] CUR_CENTI [0:3] = '{6'h05, 6'h0a, 6'h14, 6'h1e};
	localparam logic [9:0] MAINT_MIN [0:3] = '{10'h000, 10'h00f, 10'h01e,
		10'h03c};
	localparam logic [9:0] FAST_MIN [0:3] = '{10'h04b, 10'h096, 10'h12c,
		10'h258};
	localparam logic [9:0] PRE_MIN [0:3] = '{10'h01e, 10'h03c, 10'h078,
		10'h0f0};
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		DET_NONE = 2'b00,
		DET_RISE = 2'b01,
		DET_BOTH = 2'b11,
		DET_FALL = 2'b10
	} detect_opt_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic battery_pulldown_enable;
		logic [2:0] precharge_voltage_threshold;
		logic [1:0] precharge_current_select;
		logic [1:0] done_current_threshold;
		logic maintain_auto_finish;
		logic auto_recharge_enable;
		logic [1:0] maintain_timer_select;
		logic [1:0] fast_timer_select;
		logic [1:0] pre_timer_select;
		logic [2:0] step_hysteresis_select;
		logic [3:0] step_rise_threshold;
	} cfg_fields_t;
	typedef struct packed {
		logic [11:0] precharge_mv;
		logic [5:0] precharge_centi;
		logic [5:0] done_centi;
		logic [9:0] maintain_min;
		logic [9:0] fast_min;
		logic [9:0] pre_min;
		logic [11:0] step_hys_mv;
		logic [12:0] step_rise_mv;
	} cfg_decoded_t;
endpackage

// ---- testbench/test_charger_phase_config_regs.sv ----
`timescale 1ns/10ps
module test_charger_phase_config_regs import charger_cfg_pkg::*;;
	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	reg_req_t req = '0;
	logic [7:0] rd_data;
	logic rd_valid;
	logic charger_input_presence = 1'b0;
	logic [1:0] input_detect_option = 2'h0;
	cfg_fields_t cfg;
	cfg_decoded_t dec;
	int errors = 0;
	int compares = 0;
	logic [15:0] cur [4] = '{16'h0005, 16'h000a, 16'h0014, 16'h001e};
	logic [15:0] mnt [4] = '{16'h0000, 16'h000f, 16'h001e, 16'h003c};
	logic [15:0] fst [4] = '{16'h004b, 16'h0096, 16'h012c, 16'h0258};
	logic [15:0] pre [4] = '{16'h001e, 16'h003c, 16'h0078, 16'h00f0};

	always #2.5 ref_clk = ~ref_clk;

	charger_phase_config_regs i_dut (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.req(req),
		.rd_data(rd_data),
		.rd_valid(rd_valid),
		.charger_input_presence(charger_input_presence),
		.input_detect_option(input_detect_option),
		.cfg(cfg),
		.dec(dec)
	);

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Strobe raised after one edge, dropped at the sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1;
		chk(16'(rd_valid), 16'h0001);
		chk(16'(rd_data), 16'(exp));
	endtask

	// Write, then read back on the very next cycle
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1;
		chk(16'(rd_valid), 16'h0001);
		chk(16'(rd_data), 16'(d));
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		logic [7:0] v;
		logic [1:0] k;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(dec.precharge_mv), 16'h0834);
		chk(16'(dec.step_rise_mv), 16'h0ed8);
		chk(16'(dec.fast_min), 16'h004b);
		rd(PRECHG_OFS, 8'h00);
		rd(TIMER_OFS, 8'h00);
		rd(STEP_OFS, 8'h00);
		wr(8'h14, 8'hff);
		rd(8'h14, 8'h00);
		$display("Reset and unmapped test done");
		for (int i = 0; i < 8; i++) begin
			k = i[1:0];
			v = {i[0], i[2:0], k, ~k};
			wr(PRECHG_OFS, v);
			chk(16'(cfg.battery_pulldown_enable), 16'(i[0]));
			chk(16'(dec.precharge_mv), 16'h0834 + 16'h0096 * 16'(i));
			chk(16'(dec.precharge_centi), cur[k]);
			chk(16'(dec.done_centi), cur[~k]);
			rd(PRECHG_OFS, v);
		end
		$display("Precharge register test done");
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			v = {k[0], k[1], k, ~k, k};
			wr(TIMER_OFS, v);
			chk(16'(cfg.maintain_auto_finish), 16'(k[0]));
			chk(16'(cfg.auto_recharge_enable), 16'(k[1]));
			chk(16'(dec.maintain_min), mnt[k]);
			chk(16'(dec.fast_min), fst[~k]);
			chk(16'(dec.pre_min), pre[k]);
			rd(TIMER_OFS, v);
		end
		wr_rd(TIMER_OFS, 8'ha6);
		$display("Timer register test done");
		for (int i = 0; i < 16; i++) begin
			// Hysteresis kept to codes 0..5 only
			v = {1'b1, 3'(i % 6), i[3:0]};
			wr(STEP_OFS, v);
			chk(16'(dec.step_rise_mv), 16'h0ed8 + 16'h0032 * 16'(i));
			chk(16'(dec.step_hys_mv), 16'h0064 * 16'(i % 6 + 1));
			rd(STEP_OFS, v & 8'h7f);
		end
		$display("Step register test done");
		for (int o = 0; o < 4; o++) begin
			@(posedge ref_clk);
			input_detect_option <= 2'(o);
			for (int e = 0; e < 2; e++) begin
				wr(PRECHG_OFS, 8'h5a);
				wr(TIMER_OFS, 8'h5a);
				wr(STEP_OFS, 8'h5a);
				@(posedge ref_clk);
				charger_input_presence <= (e == 0);
				repeat (3) @(posedge ref_clk);
				v = (o[e] == 1'b1) ? 8'h00 : 8'h5a;
				rd(PRECHG_OFS, v);
				rd(TIMER_OFS, v);
				rd(STEP_OFS, v);
			end
		end
		$display("Presence edge test done");
		final_report();
	end
endmodule
